/* File: rtl/ptbr_pkg.sv */
// Shared constants and types for the 64-bit target burst read sequencer
package ptbr_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int HALF_W = 32;
   localparam int CMD_W = 4;
   localparam int BE_W = 8;
   localparam int NUM_WIN = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;

   // -----------------------------------------------------------------
   // Bus commands served (memory reads)
   // -----------------------------------------------------------------
   localparam logic [CMD_W-1:0] CMD_MEM_READ = 4'h6;
   localparam logic [CMD_W-1:0] CMD_MEM_READ_MULT = 4'hC;
   localparam logic [CMD_W-1:0] CMD_MEM_READ_LINE = 4'hE;

   // -----------------------------------------------------------------
   // Reset and idle values, and the FIFO room threshold
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [NUM_WIN-1:0] WIN_NONE = 2'h0;
   localparam logic [FIFO_AW:0] FIFO_ROOM_MAX = 4'h6;

   // -----------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DECODE = 7'h02,
      ST_MATCH = 7'h04,
      ST_DATA = 7'h08,
      ST_TURN = 7'h10,
      ST_RELEASE = 7'h20,
      ST_IGNORE = 7'h40
   } ptbr_state_t;

endpackage

/* File: rtl/ptbr_fifo.sv */
// Flip-flop FIFO between the back-end read data and the bus data lines
`timescale 1ns/1ns

module ptbr_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [AW:0] level
);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic doPush;
   logic doPop;

   assign inReady = (count_ff != DEPTH[AW:0]);
   assign outValid = (count_ff != '0);
   assign outData = mem_ff[rdPtr_ff];
   assign level = count_ff;
   assign doPush = inValid && inReady;
   assign doPop = outReady && outValid;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (doPush) begin
         mem_ff[wrPtr_ff] <= inData;
      end
   end

   // -----------------------------------------------------------------
   // Pointers and fill level
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b || flush) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (doPush) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (doPop) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
         if (doPush && !doPop) begin
            count_ff <= count_ff + 1'b1;
         end else if (doPop && !doPush) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

endmodule

/* File: rtl/ptbr_target.sv */
// Target-side sequencer for 64-bit burst reads toward a local back-end
`timescale 1ns/1ns

// Behaviour
// - 32-bit burst follows the 32-bit sequence; upper data half is ignored.
// - Second clock: decode, present captured address, raise wide flag if requested.
// - Third clock: window-match outputs driven on a base window hit.
// - Slow select: devseln and ack64n one clock after window match.
// - One cycle after ready seen, low strobe asserts (high strobe too on a 64-bit burst); back-end drives first QWORD.
// - trdyn and bus data only after ready on both preceding cycles.
// - irdyn and ready both asserted last cycle keep strobes asserted.
// - Turnaround: release ad, deassert devseln, ack64n, trdyn; clear match, strobes.
// - Idle clock after turnaround: stop driving devseln, ack64n and trdyn.
module ptbr_target (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic frameN,
   input wire logic req64N,
   input wire logic irdyN,
   input wire logic [ptbr_pkg::DATA_W-1:0] adIn,
   input wire logic [ptbr_pkg::BE_W-1:0] cbeN,
   output logic [ptbr_pkg::DATA_W-1:0] adOut,
   output logic adLowOe,
   output logic adHighOe,
   output logic devselNOut,
   output logic devselNOe,
   output logic ack64NOut,
   output logic ack64NOe,
   output logic trdyNOut,
   output logic trdyNOe,
   input wire logic selectResponseSpeed,
   input wire logic [ptbr_pkg::NUM_WIN*ptbr_pkg::ADDR_W-1:0] windowBase,
   input wire logic [ptbr_pkg::NUM_WIN*ptbr_pkg::ADDR_W-1:0] windowMask,
   input wire logic [ptbr_pkg::NUM_WIN-1:0] windowEnable,
   output logic [ptbr_pkg::ADDR_W-1:0] targetAddrToBackend,
   output logic [ptbr_pkg::CMD_W-1:0] commandToBackend,
   output logic wideTransferRequestFlag,
   output logic [ptbr_pkg::NUM_WIN-1:0] windowMatch,
   input wire logic backendReadyN,
   input wire logic [ptbr_pkg::DATA_W-1:0] localDataIn,
   output logic lowDwordTransferN,
   output logic highDwordTransferN
);

   ptbr_pkg::ptbr_state_t state_ff;
   ptbr_pkg::ptbr_state_t nxt_state;
   logic frameD1_ff;
   logic [ptbr_pkg::ADDR_W-1:0] addr_ff;
   logic [ptbr_pkg::CMD_W-1:0] cmd_ff;
   logic wide_ff;
   logic [ptbr_pkg::NUM_WIN-1:0] match_ff;
   logic devselN_ff;
   logic ack64N_ff;
   logic trdyN_ff;
   logic selOe_ff;
   logic ackOe_ff;
   logic [ptbr_pkg::DATA_W-1:0] ad_ff;
   logic adLowOe_ff;
   logic adHighOe_ff;
   logic lowXferN_ff;
   logic highXferN_ff;
   logic started_ff;
   logic rdyD1_ff;
   logic [ptbr_pkg::NUM_WIN-1:0] hitVec;
   logic isRead;
   logic frameStart;
   logic phaseDone;
   logic lastDone;
   logic rdyNow;
   logic pushNow;
   logic loadSlot;
   logic nxt_load;
   logic nxt_strobe;
   logic bypass;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [ptbr_pkg::DATA_W-1:0] fifoOutData;
   logic [ptbr_pkg::FIFO_AW:0] fifoLevel;
   logic fifoFlush;
   logic [ptbr_pkg::DATA_W-1:0] loadData;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   generate
      for (genvar w = 0; w < ptbr_pkg::NUM_WIN; w++) begin : g_win
         assign hitVec[w] = windowEnable[w] &&
            ((addr_ff & windowMask[w*ptbr_pkg::ADDR_W +: ptbr_pkg::ADDR_W]) ==
             (windowBase[w*ptbr_pkg::ADDR_W +: ptbr_pkg::ADDR_W] &
              windowMask[w*ptbr_pkg::ADDR_W +: ptbr_pkg::ADDR_W]));
      end
   endgenerate

   assign isRead = (cmd_ff == ptbr_pkg::CMD_MEM_READ) ||
                   (cmd_ff == ptbr_pkg::CMD_MEM_READ_MULT) ||
                   (cmd_ff == ptbr_pkg::CMD_MEM_READ_LINE);
   assign frameStart = !frameN && frameD1_ff;
   assign rdyNow = !backendReadyN;
   assign phaseDone = !trdyN_ff && !irdyN;
   // Final phase is the one taken while the master has framen high
   assign lastDone = phaseDone && frameN;
   assign pushNow = !lowXferN_ff;

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ptbr_pkg::ST_IDLE: begin
            if (frameStart) begin
               nxt_state = ptbr_pkg::ST_DECODE;
            end
         end
         ptbr_pkg::ST_DECODE: begin
            if (isRead && (hitVec != ptbr_pkg::WIN_NONE)) begin
               nxt_state = ptbr_pkg::ST_MATCH;
            end else begin
               nxt_state = ptbr_pkg::ST_IGNORE;
            end
         end
         ptbr_pkg::ST_MATCH: begin
            nxt_state = ptbr_pkg::ST_DATA;
         end
         ptbr_pkg::ST_DATA: begin
            if (lastDone) begin
               nxt_state = ptbr_pkg::ST_TURN;
            end
         end
         ptbr_pkg::ST_TURN: begin
            nxt_state = ptbr_pkg::ST_RELEASE;
         end
         ptbr_pkg::ST_RELEASE: begin
            nxt_state = ptbr_pkg::ST_IDLE;
         end
         ptbr_pkg::ST_IGNORE: begin
            if (frameN && irdyN) begin
               nxt_state = ptbr_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = ptbr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_ff <= ptbr_pkg::ST_IDLE;
         frameD1_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         frameD1_ff <= frameN;
      end
   end

   // -----------------------------------------------------------------
   // Address phase capture toward the back-end
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         addr_ff <= ptbr_pkg::ADDR_RST;
         cmd_ff <= '0;
         wide_ff <= 1'b0;
      end else if (state_ff == ptbr_pkg::ST_IDLE && frameStart) begin
         addr_ff <= adIn[ptbr_pkg::ADDR_W-1:0];
         cmd_ff <= cbeN[ptbr_pkg::CMD_W-1:0];
         wide_ff <= !req64N;
      end else if (state_ff == ptbr_pkg::ST_RELEASE || state_ff == ptbr_pkg::ST_IGNORE) begin
         wide_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Window match
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         match_ff <= ptbr_pkg::WIN_NONE;
      end else if (state_ff == ptbr_pkg::ST_DECODE) begin
         match_ff <= isRead ? hitVec : ptbr_pkg::WIN_NONE;
      end else if (lastDone || state_ff == ptbr_pkg::ST_IGNORE) begin
         match_ff <= ptbr_pkg::WIN_NONE;
      end
   end

   // -----------------------------------------------------------------
   // Select and 64-bit acknowledge
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         devselN_ff <= 1'b1;
         ack64N_ff <= 1'b1;
         selOe_ff <= 1'b0;
         ackOe_ff <= 1'b0;
      end else if ((state_ff == ptbr_pkg::ST_MATCH && selectResponseSpeed) ||
                   (state_ff == ptbr_pkg::ST_DECODE && !selectResponseSpeed &&
                    isRead && hitVec != ptbr_pkg::WIN_NONE)) begin
         devselN_ff <= 1'b0;
         selOe_ff <= 1'b1;
         ack64N_ff <= !wide_ff;
         ackOe_ff <= wide_ff;
      end else if (lastDone) begin
         devselN_ff <= 1'b1;
         ack64N_ff <= 1'b1;
      end else if (state_ff == ptbr_pkg::ST_TURN) begin
         selOe_ff <= 1'b0;
         ackOe_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Back-end ready history
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rdyD1_ff <= 1'b0;
      end else begin
         rdyD1_ff <= rdyNow && (state_ff == ptbr_pkg::ST_DATA);
      end
   end

   // -----------------------------------------------------------------
   // Local transfer strobes
   // -----------------------------------------------------------------
   // First strobe needs only ready; later ones need irdyn with ready,
   // and two free FIFO slots so a fetched QWORD always has a home
   assign nxt_strobe = (state_ff == ptbr_pkg::ST_DATA) && rdyNow && !lastDone &&
                       (!started_ff || !irdyN) &&
                       (fifoLevel <= ptbr_pkg::FIFO_ROOM_MAX);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         lowXferN_ff <= 1'b1;
         highXferN_ff <= 1'b1;
         started_ff <= 1'b0;
      end else begin
         lowXferN_ff <= !nxt_strobe;
         highXferN_ff <= !(nxt_strobe && wide_ff);
         if (state_ff != ptbr_pkg::ST_DATA) begin
            started_ff <= 1'b0;
         end else if (nxt_strobe) begin
            started_ff <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read data path
   // -----------------------------------------------------------------
   // An empty FIFO passes the QWORD being fetched straight to the bus
   assign loadSlot = (state_ff == ptbr_pkg::ST_DATA) && (trdyN_ff || !irdyN) && !lastDone;
   assign nxt_load = loadSlot && rdyD1_ff && rdyNow &&
                     (fifoOutValid || pushNow);
   assign bypass = nxt_load && !fifoOutValid;
   assign loadData = fifoOutValid ? fifoOutData : localDataIn;
   assign fifoInValid = pushNow && !bypass && fifoInReady;
   assign fifoOutReady = nxt_load && fifoOutValid;
   assign fifoFlush = (state_ff == ptbr_pkg::ST_TURN);

   ptbr_fifo #(
      .WIDTH(ptbr_pkg::DATA_W),
      .DEPTH(ptbr_pkg::FIFO_DEPTH),
      .AW(ptbr_pkg::FIFO_AW)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .flush(fifoFlush),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(localDataIn),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData),
      .level(fifoLevel)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         trdyN_ff <= 1'b1;
         ad_ff <= ptbr_pkg::DATA_RST;
      end else if (nxt_load) begin
         trdyN_ff <= 1'b0;
         ad_ff <= wide_ff ? loadData :
                  {{ptbr_pkg::HALF_W{1'b0}}, loadData[ptbr_pkg::HALF_W-1:0]};
      end else if (loadSlot || lastDone) begin
         trdyN_ff <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Drive enables for the low and high data lines
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         adLowOe_ff <= 1'b0;
         adHighOe_ff <= 1'b0;
      end else if (state_ff == ptbr_pkg::ST_MATCH) begin
         adLowOe_ff <= 1'b1;
         adHighOe_ff <= wide_ff;
      end else if (lastDone || state_ff != ptbr_pkg::ST_DATA) begin
         adLowOe_ff <= 1'b0;
         adHighOe_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign adOut = ad_ff;
   assign adLowOe = adLowOe_ff;
   assign adHighOe = adHighOe_ff;
   assign devselNOut = devselN_ff;
   assign devselNOe = selOe_ff;
   assign trdyNOut = trdyN_ff;
   assign trdyNOe = selOe_ff;
   assign ack64NOut = ack64N_ff;
   assign ack64NOe = ackOe_ff;
   assign targetAddrToBackend = addr_ff;
   assign commandToBackend = cmd_ff;
   assign wideTransferRequestFlag = wide_ff;
   assign windowMatch = match_ff;
   assign lowDwordTransferN = lowXferN_ff;
   assign highDwordTransferN = highXferN_ff;

endmodule

/* File: bench/ptbr_assertions.sv */
// Concurrent checks on the ports of the 64-bit target burst read sequencer
`timescale 1ns/1ns
module ptbr_assertions (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic frameN,
   input wire logic irdyN,
   input wire logic [63:0] adIn,
   input wire logic [7:0] cbeN,
   input wire logic adLowOe,
   input wire logic adHighOe,
   input wire logic devselNOut,
   input wire logic devselNOe,
   input wire logic ack64NOut,
   input wire logic ack64NOe,
   input wire logic trdyNOut,
   input wire logic trdyNOe,
   input wire logic selectResponseSpeed,
   input wire logic [63:0] windowBase,
   input wire logic [63:0] windowMask,
   input wire logic [1:0] windowEnable,
   input wire logic wideTransferRequestFlag,
   input wire logic [1:0] windowMatch,
   input wire logic backendReadyN,
   input wire logic lowDwordTransferN,
   input wire logic highDwordTransferN
);
   logic framePrev_ff;
   logic both_ff;
   logic start;
   logic rd;
   logic last;
   logic [1:0] hit;
   always_ff @(posedge sys_clk) begin
      framePrev_ff <= !rst_b || frameN;
      both_ff <= !irdyN && !backendReadyN && !frameN;
   end
   // Frame start seen only while no access is in progress
   assign start = !frameN && framePrev_ff && !devselNOe && !trdyNOe && windowMatch == 2'h0;
   assign rd = cbeN[3:0] == 4'h6 || cbeN[3:0] == 4'hC || cbeN[3:0] == 4'hE;
   assign last = trdyNOe && !trdyNOut && !irdyN && frameN;
   assign hit[0] = windowEnable[0] && ((adIn[31:0] ^ windowBase[31:0]) & windowMask[31:0]) == 0;
   assign hit[1] = windowEnable[1] && ((adIn[31:0] ^ windowBase[63:32]) & windowMask[63:32]) == 0;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   a_match_third: assert property (
      start && rd |-> ##2 windowMatch == $past(hit, 2)) else $error("window match wrong");
   a_no_select: assert property (
      start && (!rd || hit == 2'h0) |=> (!devselNOe && !ack64NOe && windowMatch == 2'h0)[*6])
      else $error("select on refused access");
   a_slow_select: assert property (
      selectResponseSpeed && $rose(|windowMatch) |-> !devselNOe ##1 (devselNOe && !devselNOut
      && ack64NOe == wideTransferRequestFlag && (!ack64NOut || !ack64NOe)))
      else $error("select timing wrong");
   a_strobe_pair: assert property (
      $fell(lowDwordTransferN) |-> !$past(backendReadyN)
      && highDwordTransferN == !wideTransferRequestFlag) else $error("strobe start wrong");
   a_trdy_ready: assert property (
      trdyNOe && $fell(trdyNOut) |-> !$past(backendReadyN) && !$past(backendReadyN, 2)
      && adLowOe && adHighOe == wideTransferRequestFlag) else $error("target ready early");
   a_strobe_hold: assert property (
      devselNOe && !devselNOut && both_ff |-> !lowDwordTransferN) else $error("strobe dropped");
   a_turn_around: assert property (
      last |=> devselNOe && devselNOut && trdyNOut && (ack64NOut || !ack64NOe) && !adLowOe
      && !adHighOe && windowMatch == 2'h0 && lowDwordTransferN && highDwordTransferN)
      else $error("turnaround wrong");
   a_idle_release: assert property (
      last |-> ##2 !devselNOe && !trdyNOe && !ack64NOe) else $error("lines not released");
endmodule

bind ptbr_target ptbr_assertions u_checks (
   .sys_clk, .rst_b, .frameN, .irdyN, .adIn, .cbeN, .adLowOe, .adHighOe, .devselNOut,
   .devselNOe, .ack64NOut, .ack64NOe, .trdyNOut, .trdyNOe, .selectResponseSpeed, .windowBase,
   .windowMask, .windowEnable, .wideTransferRequestFlag, .windowMatch, .backendReadyN,
   .lowDwordTransferN, .highDwordTransferN
);

/* File: bench/ptbr_backend.sv */
// Back-end application model: ready handshake and QWORD source
`timescale 1ns/1ns
module ptbr_backend (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [1:0] windowMatch,
   input wire logic lowDwordTransferN,
   input wire logic [3:0] stallCycles,
   output logic backendReadyN = 1'b1,
   output logic [63:0] localDataIn
);
   logic [3:0] waitCnt = 4'h0;
   logic [31:0] index = 32'h0;
   logic [63:0] qword;
   assign qword = {32'hA000_0000 | index, 32'h5000_0000 | index};
   // Unselected: inverted pattern so stale data never passes for a QWORD
   assign localDataIn = windowMatch != 2'h0 ? qword : ~qword;
   always @(posedge sys_clk) begin
      if (!rst_b || windowMatch == 2'h0) begin
         waitCnt <= 4'h0;
         backendReadyN <= 1'b1;
         index <= 32'h0;
      end else begin
         if (waitCnt >= stallCycles) begin
            backendReadyN <= 1'b0;
         end else begin
            waitCnt <= waitCnt + 4'h1;
         end
         if (!lowDwordTransferN) begin
            index <= index + 32'h1;
         end
      end
   end
endmodule

/* File: bench/pci64_target_burst_read_bench.sv */
// Self-checking bench for the 64-bit target burst read sequencer
`timescale 1ns/1ns
module pci64_target_burst_read_bench;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic frameN = 1'b1;
   logic req64N = 1'b1;
   logic irdyN = 1'b1;
   logic [63:0] adIn = 64'h0;
   logic [7:0] cbeN = 8'hFF;
   logic [1:0] windowEnable = 2'h3;
   logic [3:0] stallCycles = 4'h0;
   logic selectResponseSpeed = 1'b1;
   logic [63:0] adOut, localDataIn;
   logic [31:0] targetAddrToBackend;
   logic [3:0] commandToBackend;
   logic [1:0] windowMatch;
   logic adLowOe, adHighOe, devselNOut, devselNOe, ack64NOut, ack64NOe, trdyNOut, trdyNOe;
   logic wideTransferRequestFlag, backendReadyN, lowDwordTransferN, highDwordTransferN;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   always #50 sys_clk = ~sys_clk;

   ptbr_target DUT (
      .sys_clk, .rst_b, .frameN, .req64N, .irdyN, .adIn, .cbeN, .adOut, .adLowOe, .adHighOe,
      .devselNOut, .devselNOe, .ack64NOut, .ack64NOe, .trdyNOut, .trdyNOe,
      .selectResponseSpeed, .windowBase(64'h2000_0000_1000_0000),
      .windowMask(64'hFFF0_0000_FFFF_0000), .windowEnable, .targetAddrToBackend,
      .commandToBackend, .wideTransferRequestFlag, .windowMatch, .backendReadyN,
      .localDataIn, .lowDwordTransferN, .highDwordTransferN
   );

   ptbr_backend backend (
      .sys_clk, .rst_b, .windowMatch, .lowDwordTransferN, .stallCycles, .backendReadyN,
      .localDataIn
   );

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_mismatch++;
         $display("unexpected hang at %0t", $time);
         stop_test();
      end
   end

   task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Master side of one read; bus inputs change at the falling edge only
   task automatic run_burst(input logic [31:0] addr, input logic [3:0] cmd, input logic wide,
         input int phases, input int irdyAt, input logic [3:0] stall, input logic [1:0] win);
      int k;
      int n;
      int done;
      int first;
      logic [63:0] exp;
      logic sel;
      k = 0;
      n = 0;
      done = 0;
      first = 0;
      stallCycles = stall;
      @(negedge sys_clk);
      frameN = 1'b0;
      req64N = !wide;
      adIn = {32'h0, addr};
      cbeN = {4'h0, cmd};
      while (k < 40 && done < 3) begin
         @(negedge sys_clk);
         k++;
         if (k == 1) begin
            check_val(targetAddrToBackend, addr);
            check_val(commandToBackend, cmd);
            check_val(wideTransferRequestFlag, wide);
            cbeN = 8'h00;
         end
         if (k == 2) begin
            check_val(windowMatch, win);
         end
         // Select and 64-bit acknowledge in clock 3 (fast) or clock 4 (slow)
         if (k == 2 || k == 3) begin
            sel = win != 2'h0 && (k == 3 || !selectResponseSpeed);
            check_val({devselNOe, !devselNOut}, {2{sel}});
            check_val({ack64NOe, !ack64NOut}, {2{sel && wide}});
         end
         adIn = ~adIn;
         if (n == phases) begin
            irdyN = 1'b1;
            cbeN = ~cbeN;
            if (done == 0) begin
               check_val({devselNOe, devselNOut, trdyNOut}, {win != 2'h0, 2'h3});
               check_val({adLowOe, adHighOe, windowMatch}, 4'h0);
            end else if (done == 1) begin
               check_val({devselNOe, ack64NOe, trdyNOe}, 3'h0);
            end
            done++;
         end else begin
            if (k + 1 >= irdyAt) begin
               irdyN = 1'b0;
            end
            // With no select the master gives up after five clocks
            if (n == phases - 1 || (win == 2'h0 && k >= 5)) begin
               frameN = 1'b1;
               req64N = 1'b1;
            end
            if (win == 2'h0 && k >= 6) begin
               n = phases;
            end
         end
         if (first == 0 && trdyNOe === 1'b1 && trdyNOut === 1'b0) begin
            first = k;
            check_val(64'(k), 64'(5 + stall));
         end
         if (trdyNOe === 1'b1 && trdyNOut === 1'b0 && irdyN === 1'b0 && n < phases) begin
            exp = {32'hA000_0000 | n, 32'h5000_0000 | n};
            if (!wide) begin
               exp[63:32] = 32'h0;
            end
            check_val(adOut, exp);
            n++;
         end
      end
      check_val(64'(n), 64'(phases));
   endtask

   task automatic test_wide_prompt();
      run_burst(32'h1000_0040, 4'h6, 1'b1, 3, 2, 4'h0, 2'h1);
   endtask

   task automatic test_wide_slow();
      run_burst(32'h2003_0000, 4'hC, 1'b1, 4, 5, 4'h3, 2'h2);
   endtask

   task automatic test_narrow();
      run_burst(32'h1000_0100, 4'hE, 1'b0, 2, 2, 4'h0, 2'h1);
   endtask

   task automatic test_refused();
      run_burst(32'h3000_0000, 4'h6, 1'b1, 2, 2, 4'h0, 2'h0);
      run_burst(32'h1000_0000, 4'h7, 1'b1, 2, 2, 4'h0, 2'h0);
      windowEnable = 2'h1;
      run_burst(32'h2003_0000, 4'hC, 1'b1, 2, 2, 4'h0, 2'h0);
      windowEnable = 2'h3;
   endtask

   task automatic test_fast_select();
      selectResponseSpeed = 1'b0;
      run_burst(32'h1000_0200, 4'h6, 1'b1, 3, 2, 4'h1, 2'h1);
      run_burst(32'h2000_0000, 4'hE, 1'b0, 2, 3, 4'h0, 2'h2);
      selectResponseSpeed = 1'b1;
   endtask

   initial begin
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      test_wide_prompt();
      test_wide_slow();
      test_narrow();
      test_refused();
      test_fast_select();
      test_wide_prompt();
      stop_test();
   end
endmodule
